//--- dv/cpu_seq_model.sv
`timescale 1ns/1ps
// Sequencer side: takes a request after a random pause, never twice running
module cpu_seq_model (
    input  wire logic clk_i,
    input  wire logic en_i,
    input  wire logic irq_req_i,
    output logic      take_o
);
    initial take_o = 1'b0;
    always @(posedge clk_i) begin
        take_o <= en_i && irq_req_i && !take_o && ($urandom_range(1, 0) == 1);
    end
endmodule // cpu_seq_model

//--- dv/nested_irq_priority_ctrl_tb.sv
`timescale 1ns/1ps
module nested_irq_priority_ctrl_tb;
    import nested_irq_pkg::*;
    logic        clk = 0, rst_b = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, en = 0;
    logic        awready, wready, bvalid, arready, rvalid, take, irq_req, bm, bu, wake, irq;
    logic        ce = 1;
    logic [7:0]  awaddr = 0, araddr = 0, d, cur = 8'hff;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp, lvl;
    logic [13:0] pend = 0;
    logic [3:0]  vnum;
    logic [15:0] vaddr;
    logic [33:0] q[$];
    cpu_instr_t  instr = '0;
    power_mode_t mode;
    int          bad_count = 0, compares = 0;
    cpu_op_t     ops[6] = '{OP_ENABLE_IRQ, OP_DISABLE_IRQ, OP_POP_FLAGS, OP_IRQ_RETURN,
                            OP_WAIT_FOR_IRQ, OP_DISABLE_IRQ};
    logic [1:0]  lv[6] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b10, 2'b11};
    always #2 clk = ~clk;
    nested_irq_priority_ctrl dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_pending_i(pend),
        .instr_i(instr), .take_i(take), .irq_req_o(irq_req), .vec_num_o(vnum),
        .vec_addr_o(vaddr), .cpu_level_o(lvl), .branch_if_masked_o(bm),
        .branch_if_unmasked_o(bu), .power_mode_o(mode), .wake_o(wake), .irq_o(irq));
    cpu_seq_model seq (.clk_i(clk), .en_i(en), .irq_req_i(irq_req), .take_o(take));
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awv <= 1;
        wv <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awv && awready) awv <= 0;
            if (wv && wready) wv <= 0;
        end while (!bvalid);
        bready <= 0;
        chk("bresp", bresp, er);
        #1;
    endtask
    // Expected read results queue up here; the monitor below consumes them
    task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        q.push_back({er, 24'h0, v});
        @(posedge clk);
        araddr <= a;
        arv <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arv && arready) arv <= 0;
        end while (!rvalid);
        rready <= 0;
    endtask
    always @(posedge clk) if (rst_b && rvalid && rready) chk("rdata", {rresp, rdata}, q.pop_front());
    task automatic op(input cpu_op_t o, input logic [1:0] pl);
        @(posedge clk);
        instr <= '{valid: 1'b1, op: o, pop_level: pl};
        @(posedge clk);
        instr <= '0;
        #1;
    endtask
    // Pending is dropped at the take edge, else vector 0 would be taken again
    task automatic grant(input logic [13:0] p);
        @(posedge clk);
        pend <= p;
        en <= 1;
        do begin
            @(posedge clk);
        end while (!(take && irq_req));
        pend <= 0;
        en <= 0;
        #1;
    endtask
    initial begin
        #40000;
        bad_count++;
        summarize();
    end
    initial begin
        void'($urandom(68));
        repeat (5) @(posedge clk);
        rst_b <= 1;
        for (int i = 0; i < 4; i++) rd(8'h90 + 8'(4 * i), 8'hff, RESP_OKAY);
        rd(8'h00, 8'h00, RESP_SLVERR);
        wr(8'h00, 8'h12, RESP_SLVERR);
        wr(8'h90, 8'hcf, RESP_OKAY);
        wr(8'h90, 8'h64, RESP_OKAY);
        rd(8'h90, 8'h44, RESP_OKAY);
        wr(8'h9c, 8'h00, RESP_OKAY);
        rd(8'h9c, 8'hf0, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(8'h94, d, RESP_OKAY);
            for (int k = 0; k < 4; k++) if (d[2*k+:2] != CODE_L0) cur[2*k+:2] = d[2*k+:2];
            rd(8'h94, cur, RESP_OKAY);
        end
        for (int i = 0; i < 6; i++) begin
            op(ops[i], lv[i]);
            chk("level", lvl, lv[i]);
            chk("masked", {bm, bu}, {lv[i] == 2'b11, lv[i] != 2'b11});
        end
        wr(8'h94, 8'h00, RESP_OKAY);
        op(OP_ENABLE_IRQ, 2'b00);
        // Clock enable low must freeze the level against an instruction
        ce <= 0;
        op(OP_DISABLE_IRQ, 2'b00);
        chk("frozen", lvl, 2'b10);
        ce <= 1;
        grant(14'h0060);
        chk("vector", {vnum, vaddr, lvl}, {4'd5, 16'hfff0, 2'b00});
        wr(8'h94, 8'h0c, RESP_OKAY);
        grant(14'h0020);
        chk("reenter", {vnum, lvl}, {4'd5, 2'b11});
        op(OP_DISABLE_IRQ, 2'b00);
        grant(14'h0001);
        chk("top", {vnum, vaddr, lvl}, {4'd0, 16'hfffa, 2'b11});
        op(OP_SW_TRAP, 2'b00);
        chk("trap", {vaddr, lvl}, {16'hfffc, 2'b11});
        rd(8'ha8, 8'h05, RESP_OKAY);
        chk("irq", irq, 1'b0);
        wr(8'hac, 8'h01, RESP_OKAY);
        chk("irq", irq, 1'b1);
        wr(8'ha8, 8'h07, RESP_OKAY);
        chk("irq", irq, 1'b0);
        op(OP_HALT, 2'b00);
        chk("halt", {mode, lvl}, {MODE_HALT, 2'b10});
        pend <= 14'h1f00;
        @(posedge clk);
        #1;
        chk("nowake", {mode, wake, irq_req}, {MODE_HALT, 2'b00});
        pend <= 14'h3f80;
        @(posedge clk);
        #1;
        chk("wake", {wake, irq_req}, 2'b00);
        wr(8'hb0, 8'h01, RESP_OKAY);
        chk("mode", {mode, irq_req}, {MODE_RUN, 1'b1});
        pend <= 14'h0000;
        wr(8'hb0, 8'h04, RESP_OKAY);
        op(OP_HALT, 2'b00);
        pend <= 14'h0005;
        @(posedge clk);
        #1;
        chk("actwake", {mode, wake}, {MODE_ACT_HALT, 1'b0});
        pend <= 14'h0002;
        #1;
        chk("actwake", wake, 1'b1);
        @(posedge clk);
        #1;
        chk("actrun", mode, MODE_RUN);
        summarize();
    end
endmodule // nested_irq_priority_ctrl_tb

//--- rtl/irq_arbiter.sv
`timescale 1ns/1ps
module irq_arbiter #(
    parameter int NUM_VEC = 14
) (
    input  wire logic [NUM_VEC-1:0]   pending_i,
    input  wire logic [2*NUM_VEC-1:0] prio_i,
    input  wire logic [1:0]           cpu_rank_i,
    output logic                      win_valid_o,
    output logic [3:0]                win_num_o,
    output logic [1:0]                win_rank_o
);
    import nested_irq_pkg::*;

    // Winner number is four bits wide
    if (NUM_VEC < 2 || NUM_VEC > 16) begin : g_bad_num_vec
        $error("irq_arbiter: NUM_VEC out of range");
    end

    logic [1:0] rank;

    // Downward scan with >= leaves the lowest number on equal levels
    always_comb begin
        win_valid_o = 1'b0;
        win_num_o   = 4'h0;
        win_rank_o  = 2'd0;
        rank        = 2'd0;
        for (int i = NUM_VEC - 1; i >= 1; i--) begin
            rank = level_rank(prio_i[2*i +: 2]);
            if (pending_i[i] && rank > cpu_rank_i &&
                (!win_valid_o || rank >= win_rank_o)) begin
                win_valid_o = 1'b1;
                win_num_o   = 4'(i);
                win_rank_o  = rank;
            end
        end
        // Top vector ignores its stored pair and passes the masked level
        if (pending_i[TOP_VEC]) begin
            win_valid_o = 1'b1;
            win_num_o   = 4'h0;
            win_rank_o  = 2'd3;
        end
    end

endmodule // irq_arbiter

//--- rtl/nested_irq_pkg.sv
package nested_irq_pkg;

    localparam int          NUM_VEC          = 14;
    localparam int          TLI_VEC_UNUSED   = 0;
    localparam int          TOP_VEC          = 0;
    localparam int          TIMEBASE_VEC     = 1;
    localparam int          SPI_VEC          = 7;
    localparam int          ART_VEC          = 13;

    localparam logic [7:0]  PRIO_RESET       = 8'hff;
    localparam logic [1:0]  CODE_L0          = 2'b10;
    localparam logic [1:0]  CODE_L1          = 2'b01;
    localparam logic [1:0]  CODE_L2          = 2'b00;
    localparam logic [1:0]  CODE_L3          = 2'b11;
    localparam logic [3:0]  PRIO3_FIXED_HI   = 4'hf;

    localparam logic [15:0] RESET_VEC_ADDR   = 16'hfffe;
    localparam logic [15:0] TRAP_VEC_ADDR    = 16'hfffc;
    localparam logic [15:0] VEC0_ADDR        = 16'hfffa;

    // Vectors 0..6 always leave Halt; 7 and 13 depend on peripheral mode
    localparam logic [13:0] HALT_WAKE_ALWAYS = 14'h007f;

    // Register indices, byte address is four times the index
    localparam logic [7:0]  IDX_PRIO0        = 8'h24;
    localparam logic [7:0]  IDX_PRIO1        = 8'h25;
    localparam logic [7:0]  IDX_PRIO2        = 8'h26;
    localparam logic [7:0]  IDX_PRIO3        = 8'h27;
    localparam logic [7:0]  IDX_CPU_STATE    = 8'h29;
    localparam logic [7:0]  IDX_EVT_STATUS   = 8'h2a;
    localparam logic [7:0]  IDX_EVT_MASK     = 8'h2b;
    localparam logic [7:0]  IDX_CTRL         = 8'h2c;
    localparam int          ADDR_W           = 8;

    localparam int          CTRL_SPI_SLAVE   = 0;
    localparam int          CTRL_ART_EXT     = 1;
    localparam int          CTRL_ACT_HALT    = 2;
    localparam int          CTRL_W           = 3;
    localparam logic [2:0]  CTRL_RESET       = 3'h0;

    localparam int          EVT_TAKEN        = 0;
    localparam int          EVT_WAKE         = 1;
    localparam int          EVT_REFUSED      = 2;
    localparam int          EVT_W            = 3;
    localparam logic [2:0]  EVT_RESET        = 3'h0;

    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

    typedef enum logic [3:0] {
        MODE_RUN      = 4'b0001,
        MODE_HALT     = 4'b0010,
        MODE_ACT_HALT = 4'b0100,
        MODE_WAIT     = 4'b1000
    } power_mode_t;

    typedef enum logic [2:0] {
        OP_HALT         = 3'h0,
        OP_IRQ_RETURN   = 3'h1,
        OP_POP_FLAGS    = 3'h2,
        OP_ENABLE_IRQ   = 3'h3,
        OP_DISABLE_IRQ  = 3'h4,
        OP_SW_TRAP      = 3'h5,
        OP_WAIT_FOR_IRQ = 3'h6,
        OP_OTHER        = 3'h7
    } cpu_op_t;

    typedef struct packed {
        logic       valid;
        cpu_op_t    op;
        logic [1:0] pop_level;
    } cpu_instr_t;

    typedef struct packed {
        logic spi_slave;
        logic art_ext_clk;
    } wake_cfg_t;

    function automatic logic [1:0] level_rank(input logic [1:0] code);
        case (code)
            CODE_L0: level_rank = 2'd0;
            CODE_L1: level_rank = 2'd1;
            CODE_L2: level_rank = 2'd2;
            default: level_rank = 2'd3;
        endcase
    endfunction

    function automatic logic [15:0] vec_addr(input logic [3:0] num);
        vec_addr = 16'(VEC0_ADDR - {11'h0, num, 1'b0});
    endfunction

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx[ADDR_W-3:0], 2'b00};
    endfunction

endpackage

//--- rtl/nested_irq_priority_ctrl.sv
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module nested_irq_priority_ctrl #(
    parameter int NUM_VEC       = 14,
    parameter bit FLASH_VARIANT = 1'b1
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       ce_i,
    input  wire logic [7:0]                 s_axi_awaddr_i,
    input  wire logic                       s_axi_awvalid_i,
    output logic                            s_axi_awready_o,
    input  wire logic [31:0]                s_axi_wdata_i,
    input  wire logic [3:0]                 s_axi_wstrb_i,
    input  wire logic                       s_axi_wvalid_i,
    output logic                            s_axi_wready_o,
    output logic [1:0]                      s_axi_bresp_o,
    output logic                            s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    input  wire logic [7:0]                 s_axi_araddr_i,
    input  wire logic                       s_axi_arvalid_i,
    output logic                            s_axi_arready_o,
    output logic [31:0]                     s_axi_rdata_o,
    output logic [1:0]                      s_axi_rresp_o,
    output logic                            s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i,
    input  wire logic [13:0]                irq_pending_i,
    input  wire nested_irq_pkg::cpu_instr_t instr_i,
    input  wire logic                       take_i,
    output logic                            irq_req_o,
    output logic [3:0]                      vec_num_o,
    output logic [15:0]                     vec_addr_o,
    output logic [1:0]                      cpu_level_o,
    output logic                            branch_if_masked_o,
    output logic                            branch_if_unmasked_o,
    output nested_irq_pkg::power_mode_t     power_mode_o,
    output logic                            wake_o,
    output logic                            irq_o
);
    import nested_irq_pkg::*;

    // Register map is laid out for exactly fourteen vectors
    if (NUM_VEC != 14) begin : g_bad_num_vec
        $error("nested_irq_priority_ctrl: NUM_VEC must be 14");
    end

    // Register state
    logic [27:0]       prio;
    logic [27:0]       next_prio;
    logic [CTRL_W-1:0] ctrl;
    logic [EVT_W-1:0]  evt_status;
    logic [EVT_W-1:0]  evt_mask;
    logic [1:0]        cpu_level;
    logic [1:0]        next_cpu_level;
    power_mode_t       mode;
    power_mode_t       next_mode;

    // Bus state
    logic [7:0]        aw_addr;
    logic              aw_full;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              w_full;

    // Decoding
    logic              aw_hs;
    logic              w_hs;
    logic              ar_hs;
    logic              wr_fire;
    logic [2:0]        wr_prio_idx;
    logic              wr_prio;
    logic              wr_known;
    logic              wr_refused;
    logic [31:0]       rd_mux;
    logic              rd_known;
    logic              win_valid;
    logic [3:0]        win_num;
    logic [1:0]        win_rank;
    logic              take;
    logic              instr_fire;
    logic              wake;
    logic [EVT_W-1:0]  evt_set;
    logic [EVT_W-1:0]  evt_clr;
    wake_cfg_t         wake_cfg;

    assign aw_hs   = s_axi_awvalid_i & s_axi_awready_o;
    assign w_hs    = s_axi_wvalid_i & s_axi_wready_o;
    assign ar_hs   = s_axi_arvalid_i & s_axi_arready_o;
    assign wr_fire = ce_i & aw_full & w_full & ~s_axi_bvalid_o;

    assign s_axi_awready_o = ce_i & ~aw_full;
    assign s_axi_wready_o  = ce_i & ~w_full;
    assign s_axi_arready_o = ce_i & ~s_axi_rvalid_o;

    assign wr_prio_idx = (aw_addr == reg_addr(IDX_PRIO0)) ? 3'd0 :
                         (aw_addr == reg_addr(IDX_PRIO1)) ? 3'd1 :
                         (aw_addr == reg_addr(IDX_PRIO2)) ? 3'd2 :
                         (aw_addr == reg_addr(IDX_PRIO3)) ? 3'd3 : 3'd4;
    assign wr_prio  = ~wr_prio_idx[2];
    assign wr_known = wr_prio
                    | (aw_addr == reg_addr(IDX_CPU_STATE))
                    | (aw_addr == reg_addr(IDX_EVT_STATUS))
                    | (aw_addr == reg_addr(IDX_EVT_MASK))
                    | (aw_addr == reg_addr(IDX_CTRL));

    // Pair merge: a level-0 code leaves the old pair in place
    always_comb begin
        next_prio  = prio;
        wr_refused = 1'b0;
        for (int p = 0; p < 4; p++) begin
            if (wr_fire && wr_prio && w_lane0 &&
                (wr_prio_idx[1:0] != 2'd3 || p < 2)) begin
                if (w_data[2*p +: 2] == CODE_L0) begin
                    wr_refused = 1'b1;
                end else begin
                    next_prio[8*wr_prio_idx[1:0] + 2*p +: 2] = w_data[2*p +: 2];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            prio <= {PRIO_RESET[3:0], PRIO_RESET, PRIO_RESET, PRIO_RESET};
        end else if (ce_i) begin
            prio <= next_prio;
        end
    end

    assign rd_mux =
        (s_axi_araddr_i == reg_addr(IDX_PRIO0))      ? {24'h0, prio[7:0]}   :
        (s_axi_araddr_i == reg_addr(IDX_PRIO1))      ? {24'h0, prio[15:8]}  :
        (s_axi_araddr_i == reg_addr(IDX_PRIO2))      ? {24'h0, prio[23:16]} :
        (s_axi_araddr_i == reg_addr(IDX_PRIO3))      ? {24'h0, PRIO3_FIXED_HI,
                                                        prio[27:24]} :
        (s_axi_araddr_i == reg_addr(IDX_CPU_STATE))  ? {26'h0, mode, cpu_level} :
        (s_axi_araddr_i == reg_addr(IDX_EVT_STATUS)) ? {29'h0, evt_status} :
        (s_axi_araddr_i == reg_addr(IDX_EVT_MASK))   ? {29'h0, evt_mask}   :
        (s_axi_araddr_i == reg_addr(IDX_CTRL))       ? {29'h0, ctrl}       : 32'h0;
    assign rd_known = (s_axi_araddr_i == reg_addr(IDX_PRIO0))
                    | (s_axi_araddr_i == reg_addr(IDX_PRIO1))
                    | (s_axi_araddr_i == reg_addr(IDX_PRIO2))
                    | (s_axi_araddr_i == reg_addr(IDX_PRIO3))
                    | (s_axi_araddr_i == reg_addr(IDX_CPU_STATE))
                    | (s_axi_araddr_i == reg_addr(IDX_EVT_STATUS))
                    | (s_axi_araddr_i == reg_addr(IDX_EVT_MASK))
                    | (s_axi_araddr_i == reg_addr(IDX_CTRL));

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            aw_addr <= 8'h0;
            aw_full <= 1'b0;
            w_data  <= 8'h0;
            w_lane0 <= 1'b0;
            w_full  <= 1'b0;
        end else if (ce_i) begin
            if (aw_hs) begin
                aw_addr <= s_axi_awaddr_i;
                aw_full <= 1'b1;
            end else if (wr_fire) begin
                aw_full <= 1'b0;
            end
            if (w_hs) begin
                w_data  <= s_axi_wdata_i[7:0];
                w_lane0 <= s_axi_wstrb_i[0];
                w_full  <= 1'b1;
            end else if (wr_fire) begin
                w_full  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o  <= RESP_OKAY;
            s_axi_rdata_o  <= 32'h0;
        end else if (ce_i) begin
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            if (ar_hs) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o  <= rd_known ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata_o  <= rd_mux;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // Control, event status and mask; a set in the clearing cycle survives
    assign evt_set[EVT_TAKEN]   = take | (instr_fire && instr_i.op == OP_SW_TRAP);
    assign evt_set[EVT_WAKE]    = wake;
    assign evt_set[EVT_REFUSED] = wr_refused;
    assign evt_clr = (wr_fire && w_lane0 && aw_addr == reg_addr(IDX_EVT_STATUS)) ?
                     w_data[EVT_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl       <= CTRL_RESET;
            evt_status <= EVT_RESET;
            evt_mask   <= EVT_RESET;
        end else if (ce_i) begin
            evt_status <= (evt_status & ~evt_clr) | evt_set;
            if (wr_fire && w_lane0 && aw_addr == reg_addr(IDX_CTRL)) begin
                ctrl <= w_data[CTRL_W-1:0];
            end
            if (wr_fire && w_lane0 && aw_addr == reg_addr(IDX_EVT_MASK)) begin
                evt_mask <= w_data[EVT_W-1:0];
            end
        end
    end

    assign irq_o = |(evt_status & evt_mask);

    irq_arbiter #(
        .NUM_VEC     (NUM_VEC)
    ) u_arbiter (
        .pending_i   (irq_pending_i),
        .prio_i      (prio),
        .cpu_rank_i  (level_rank(cpu_level)),
        .win_valid_o (win_valid),
        .win_num_o   (win_num),
        .win_rank_o  (win_rank)
    );

    assign wake_cfg.spi_slave   = ctrl[CTRL_SPI_SLAVE];
    assign wake_cfg.art_ext_clk = ctrl[CTRL_ART_EXT];

    wake_filter #(
        .FLASH_VARIANT (FLASH_VARIANT)
    ) u_wake (
        .mode_i        (mode),
        .pending_i     (irq_pending_i),
        .cfg_i         (wake_cfg),
        .wake_o        (wake)
    );

    // Requests go to the sequencer only while it runs or waits
    assign irq_req_o  = ce_i & win_valid & (mode == MODE_RUN || mode == MODE_WAIT);
    assign take       = irq_req_o & take_i;
    assign instr_fire = ce_i & instr_i.valid;

    // A taken vector outranks an instruction in the same cycle
    always_comb begin
        next_cpu_level = cpu_level;
        next_mode      = mode;
        if (instr_fire) begin
            case (instr_i.op)
                OP_HALT: begin
                    next_cpu_level = CODE_L0;
                    next_mode = ctrl[CTRL_ACT_HALT] ? MODE_ACT_HALT : MODE_HALT;
                end
                OP_WAIT_FOR_IRQ: begin
                    next_cpu_level = CODE_L0;
                    next_mode      = MODE_WAIT;
                end
                OP_ENABLE_IRQ:  next_cpu_level = CODE_L0;
                OP_DISABLE_IRQ: next_cpu_level = CODE_L3;
                OP_SW_TRAP:     next_cpu_level = CODE_L3;
                OP_IRQ_RETURN:  next_cpu_level = instr_i.pop_level;
                OP_POP_FLAGS:   next_cpu_level = instr_i.pop_level;
                default:        next_cpu_level = cpu_level;
            endcase
        end
        if (wake) begin
            next_mode = MODE_RUN;
        end
        if (take) begin
            next_mode      = MODE_RUN;
            next_cpu_level = (win_num == 4'h0) ? CODE_L3 : prio[2*win_num +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cpu_level  <= CODE_L3;
            mode       <= MODE_RUN;
            vec_num_o  <= 4'h0;
            vec_addr_o <= RESET_VEC_ADDR;
        end else if (ce_i) begin
            cpu_level <= next_cpu_level;
            mode      <= next_mode;
            if (take) begin
                vec_num_o  <= win_num;
                vec_addr_o <= vec_addr(win_num);
            end else if (instr_fire && instr_i.op == OP_SW_TRAP) begin
                vec_addr_o <= TRAP_VEC_ADDR;
            end
        end
    end

    assign cpu_level_o          = cpu_level;
    assign power_mode_o         = mode;
    assign wake_o               = wake;
    assign branch_if_masked_o   = (cpu_level == CODE_L3);
    assign branch_if_unmasked_o = (cpu_level != CODE_L3);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_take_top;
        take && win_num == 4'h0;
    endsequence

    sequence s_level3_after;
        ##1 cpu_level == CODE_L3 && branch_if_masked_o;
    endsequence

    AST_RANK_ABOVE_CPU: assert property (
        take && win_num != 4'h0 |-> level_rank(prio[2*win_num +: 2]) > level_rank(cpu_level))
        else $error("taken vector not above cpu level");
    AST_PRIO3_TOP_ONES: assert property (
        ar_hs && s_axi_araddr_i == reg_addr(IDX_PRIO3) |=> s_axi_rdata_o[7:4] == 4'hf)
        else $error("fourth priority register top bits not ones");
    AST_RESET_ALL_ONES: assert property (
        $rose(rst_b_i) |-> prio == 28'hfffffff && cpu_level == CODE_L3)
        else $error("priority registers not all ones after reset");
    AST_LEVEL0_KEPT: assert property (
        wr_fire && w_lane0 && wr_prio_idx == 3'd0 && w_data[5:4] == CODE_L0
        |=> prio[5:4] == $past(prio[5:4]) && evt_status[EVT_REFUSED])
        else $error("level 0 code was stored");
    AST_TOP_PASSES_MASK: assert property (
        irq_pending_i[0] && cpu_level == CODE_L3 && ce_i && mode == MODE_RUN
        |-> irq_req_o && win_num == 4'h0)
        else $error("top vector blocked at masked level");
    AST_TOP_SETS_L3: assert property (
        s_take_top |-> s_level3_after)
        else $error("top vector did not set level 3");
    AST_ENABLE_L0: assert property (
        instr_fire && instr_i.op == OP_ENABLE_IRQ && !take
        |=> cpu_level == CODE_L0 && branch_if_unmasked_o)
        else $error("enable did not load level 0");
    AST_DISABLE_L3: assert property (
        instr_fire && instr_i.op == OP_DISABLE_IRQ && !take |-> s_level3_after)
        else $error("disable did not load level 3");
    AST_VEC_ADDR: assert property (
        take |=> vec_addr_o == 16'(16'hfffa - {11'h0, $past(win_num), 1'b0}))
        else $error("vector address wrong");
    AST_HALT_NO_WAKE: assert property (
        mode == MODE_HALT && ce_i && !instr_fire && (irq_pending_i & 14'h1f00) == irq_pending_i
        && !ctrl[CTRL_ART_EXT] |=> mode == MODE_HALT)
        else $error("non-waking source left Halt");
    AST_ACT_HALT_ONLY_TB: assert property (
        FLASH_VARIANT && mode == MODE_ACT_HALT && ce_i && !irq_pending_i[TIMEBASE_VEC]
        |=> mode == MODE_ACT_HALT)
        else $error("Active Halt left without time base");

endmodule // nested_irq_priority_ctrl

//--- rtl/wake_filter.sv
`timescale 1ns/1ps
module wake_filter #(
    parameter bit FLASH_VARIANT = 1'b1
) (
    input  wire nested_irq_pkg::power_mode_t mode_i,
    input  wire logic [13:0]                 pending_i,
    input  wire nested_irq_pkg::wake_cfg_t   cfg_i,
    output logic                             wake_o
);
    import nested_irq_pkg::*;

    logic [13:0] halt_mask;
    logic [13:0] act_mask;

    assign halt_mask = HALT_WAKE_ALWAYS
                     | (14'(cfg_i.spi_slave) << SPI_VEC)
                     | (14'(cfg_i.art_ext_clk) << ART_VEC);
    assign act_mask  = FLASH_VARIANT ? (14'h1 << TIMEBASE_VEC) : halt_mask;
    assign wake_o    = (mode_i == MODE_HALT)     ? |(pending_i & halt_mask) :
                       (mode_i == MODE_ACT_HALT) ? |(pending_i & act_mask)  : 1'b0;

endmodule // wake_filter
